// File: hdl/gsw_pkg.sv
// Constants, register map and reset values of the gain switching selector.
// Function
// - The trigger condition is the lowest hex digit of the option, 0 to 8.
// - Switching happens only under manual gain tuning, tuning digit 0 or 1.
// - Condition zero never switches; base gains stay in effect.
// - Condition 1 switches while the switch input is on, condition 5 while off.
// - Condition 2 switches while command frequency is at least the threshold.
// - Condition 3 switches while position deviation is at least the threshold.
// - Condition 4 switches while motor speed is at least the threshold.
// - Condition 6 switches while command frequency is at most the threshold.
// - Condition 7 switches while position deviation is at most the threshold.
// - Condition 8 switches while motor speed is at most the threshold.
// - Threshold unit follows the condition; it resets to ten.
// - Each gain change is smoothed by a 0 to 1000 ms time constant, default 1.
// - While switched, the alternate inertia ratio replaces the base one.
// - While switched, three gains scale by their 10 to 500 percent ratios.
// - When the condition clears, all four quantities return to base values.
// - Base gain ranges are 4..1024, 40..9000 and 1..1000.
package gsw_pkg;

	localparam int GSW_NUM_PARAM = 12;
	localparam int GSW_NUM_CHAN = 4;

	localparam int GSW_IDX_INERTIA_BASE = 0;
	localparam int GSW_IDX_POS_BASE = 1;
	localparam int GSW_IDX_SPD_BASE = 2;
	localparam int GSW_IDX_INT_BASE = 3;
	localparam int GSW_IDX_COND = 4;
	localparam int GSW_IDX_THRESH = 5;
	localparam int GSW_IDX_SMOOTH = 6;
	localparam int GSW_IDX_INERTIA_ALT = 7;
	localparam int GSW_IDX_POS_RATIO = 8;
	localparam int GSW_IDX_SPD_RATIO = 9;
	localparam int GSW_IDX_INT_RATIO = 10;
	localparam int GSW_IDX_TUNING = 11;
	localparam int GSW_IDX_STATUS = 12;

	// Byte offsets; each register is one aligned word at four times its index.
	localparam logic [7:0] GSW_OFS_INERTIA_BASE = 8'h00;
	localparam logic [7:0] GSW_OFS_STATUS = 8'h30;
	localparam logic [7:0] GSW_OFS_LAST = 8'h30;

	localparam logic [31:0] GSW_RESET [GSW_NUM_PARAM] = '{
		32'h0000_0046, 32'h0000_002d, 32'h0000_00b7, 32'h0000_0022,
		32'h0000_0000, 32'h0000_000a, 32'h0000_0001, 32'h0000_0046,
		32'h0000_0064, 32'h0000_0064, 32'h0000_0064, 32'h0000_0000};
	localparam logic [31:0] GSW_MIN [GSW_NUM_PARAM] = '{
		32'h0000_0000, 32'h0000_0004, 32'h0000_0028, 32'h0000_0001,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_000a, 32'h0000_000a, 32'h0000_000a, 32'h0000_0000};
	localparam logic [31:0] GSW_MAX [GSW_NUM_PARAM] = '{
		32'h0000_04b0, 32'h0000_0400, 32'h0000_2328, 32'h0000_03e8,
		32'h0000_0008, 32'h003d_0900, 32'h0000_03e8, 32'h0000_04b0,
		32'h0000_01f4, 32'h0000_01f4, 32'h0000_01f4, 32'h0000_ffff};

	localparam logic [3:0] GSW_COND_OFF = 4'h0;
	localparam logic [3:0] GSW_COND_DI_ON = 4'h1;
	localparam logic [3:0] GSW_COND_FREQ_GE = 4'h2;
	localparam logic [3:0] GSW_COND_DEV_GE = 4'h3;
	localparam logic [3:0] GSW_COND_SPD_GE = 4'h4;
	localparam logic [3:0] GSW_COND_DI_OFF = 4'h5;
	localparam logic [3:0] GSW_COND_FREQ_LE = 4'h6;
	localparam logic [3:0] GSW_COND_DEV_LE = 4'h7;
	localparam logic [3:0] GSW_COND_SPD_LE = 4'h8;
	// Tuning digits up to this one select manual gain tuning.
	localparam logic [3:0] GSW_TUNING_MANUAL_MAX = 4'h1;

	localparam logic [31:0] GSW_PERCENT = 32'd100;
	localparam int GSW_FRAC_W = 8;
	localparam int GSW_CLK_PERIOD_NS = 20;
	localparam int GSW_TICK_TIME_NS = 1000000;
	localparam int GSW_TICK_CYCLES = GSW_TICK_TIME_NS / GSW_CLK_PERIOD_NS;

	localparam logic [1:0] GSW_RESP_OKAY = 2'b00;
	localparam logic [1:0] GSW_RESP_SLVERR = 2'b10;

endpackage

// File: hdl/gsw_gain_switch.sv
// Gain switching selector with its AXI4-Lite parameter registers.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gsw_gain_switch
	import gsw_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = GSW_TICK_CYCLES,
	parameter int unsigned ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gain_switch_in,
	input wire logic [31:0] cmd_freq_kpps,
	input wire logic [31:0] pos_deviation,
	input wire logic [31:0] motor_speed_rpm,
	output logic switch_active,
	output logic [15:0] inertia_ratio_out,
	output logic [15:0] pos_loop_gain_out,
	output logic [15:0] spd_loop_gain_out,
	output logic [15:0] spd_integral_out
);

	localparam int VAL_W = 16 + GSW_FRAC_W;

	logic [31:0] param_reg [GSW_NUM_PARAM];
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic active_reg;
	logic [31:0] tick_cnt_reg;
	logic tick;
	logic wr_fire;
	logic [VAL_W-1:0] value_reg [GSW_NUM_CHAN];
	logic [15:0] target [GSW_NUM_CHAN];
	logic manual;
	logic cond_now;

	// Returns the register index for a word address, or -1 when unmapped.
	function automatic int decode(input logic [ADDR_W-1:0] addr);
		int idx;
		idx = -1;
		if (addr[1:0] != 2'b00) begin
			idx = -1;
		end else if (addr > ADDR_W'(GSW_OFS_LAST)) begin
			idx = -1;
		end else begin
			idx = int'(addr[ADDR_W-1:2]);
		end
		return idx;
	endfunction

	// Out-of-range values are pulled to the nearest legal setting.
	function automatic logic [31:0] merge_clamp(input int idx, input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] v;
		v = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				v[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		if (v < GSW_MIN[idx]) begin
			v = GSW_MIN[idx];
		end else if (v > GSW_MAX[idx]) begin
			v = GSW_MAX[idx];
		end
		return v;
	endfunction

	function automatic logic [15:0] scale(input logic [31:0] base, input logic [31:0] ratio);
		logic [31:0] prod;
		prod = (base * ratio) / GSW_PERCENT;
		return prod[15:0];
	endfunction

	// Write channel: address and data may arrive in either order.
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			awready_reg <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && awready_reg) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end else if (wr_fire) begin
				aw_hold_reg <= 1'b0;
			end else begin
				awready_reg <= !aw_hold_reg && !bvalid_reg;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_reg <= 1'b0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			wready_reg <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && wready_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end else if (wr_fire) begin
				w_hold_reg <= 1'b0;
			end else begin
				wready_reg <= !w_hold_reg && !bvalid_reg;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= GSW_RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= (decode(awaddr_reg) < 0 || decode(awaddr_reg) == GSW_IDX_STATUS)
					? GSW_RESP_SLVERR : GSW_RESP_OKAY;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Parameter storage; the status word is read-only and refuses writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < GSW_NUM_PARAM; i++) begin
				param_reg[i] <= GSW_RESET[i];
			end
		end else if (ce && wr_fire) begin
			for (int i = 0; i < GSW_NUM_PARAM; i++) begin
				if (decode(awaddr_reg) == i) begin
					param_reg[i] <= merge_clamp(i, param_reg[i], wdata_reg, wstrb_reg);
				end
			end
		end
	end

	// Read channel: one read at a time, answered the cycle after it is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= GSW_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rresp_reg <= GSW_RESP_OKAY;
				rdata_reg <= '0;
				if (decode(s_axi_araddr) < 0) begin
					rresp_reg <= GSW_RESP_SLVERR;
				end else if (decode(s_axi_araddr) == GSW_IDX_STATUS) begin
					rdata_reg <= {30'h0, manual, active_reg};
				end else begin
					rdata_reg <= param_reg[decode(s_axi_araddr)];
				end
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end else begin
				arready_reg <= !rvalid_reg;
			end
		end
	end

	// Switching decision, re-evaluated on every enabled cycle.
	assign manual = param_reg[GSW_IDX_TUNING][3:0] <= GSW_TUNING_MANUAL_MAX;

	always_comb begin
		logic [31:0] thr;
		thr = param_reg[GSW_IDX_THRESH];
		case (param_reg[GSW_IDX_COND][3:0])
			GSW_COND_DI_ON: cond_now = gain_switch_in;
			GSW_COND_DI_OFF: cond_now = !gain_switch_in;
			GSW_COND_FREQ_GE: cond_now = cmd_freq_kpps >= thr;
			GSW_COND_DEV_GE: cond_now = pos_deviation >= thr;
			GSW_COND_SPD_GE: cond_now = motor_speed_rpm >= thr;
			GSW_COND_FREQ_LE: cond_now = cmd_freq_kpps <= thr;
			GSW_COND_DEV_LE: cond_now = pos_deviation <= thr;
			GSW_COND_SPD_LE: cond_now = motor_speed_rpm <= thr;
			default: cond_now = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_reg <= 1'b0;
		end else if (ce) begin
			active_reg <= manual && cond_now;
		end
	end

	// Targets follow the selected gain set.
	always_comb begin
		if (active_reg) begin
			target[0] = param_reg[GSW_IDX_INERTIA_ALT][15:0];
			target[1] = scale(param_reg[GSW_IDX_POS_BASE], param_reg[GSW_IDX_POS_RATIO]);
			target[2] = scale(param_reg[GSW_IDX_SPD_BASE], param_reg[GSW_IDX_SPD_RATIO]);
			target[3] = scale(param_reg[GSW_IDX_INT_BASE], param_reg[GSW_IDX_INT_RATIO]);
		end else begin
			target[0] = param_reg[GSW_IDX_INERTIA_BASE][15:0];
			target[1] = param_reg[GSW_IDX_POS_BASE][15:0];
			target[2] = param_reg[GSW_IDX_SPD_BASE][15:0];
			target[3] = param_reg[GSW_IDX_INT_BASE][15:0];
		end
	end

	// One-millisecond tick that paces the smoothing filter.
	assign tick = tick_cnt_reg == TICK_CYCLES - 1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg <= '0;
		end else if (ce) begin
			tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
		end
	end

	// Each millisecond a channel closes 1/T of its remaining gap, a discrete
	// first-order lag. Fraction bits keep small steps from stalling; the last
	// sub-unit step snaps to the target so the output always arrives.
	genvar ch;
	generate
		for (ch = 0; ch < GSW_NUM_CHAN; ch++) begin : g_chan
			logic signed [VAL_W:0] diff;
			logic signed [VAL_W:0] step;
			logic [VAL_W-1:0] goal;
			assign goal = {target[ch], {GSW_FRAC_W{1'b0}}};
			assign diff = $signed({1'b0, goal}) - $signed({1'b0, value_reg[ch]});
			assign step = diff / $signed({{(VAL_W-16){1'b0}}, param_reg[GSW_IDX_SMOOTH][15:0]});

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					value_reg[ch] <= {GSW_RESET[ch][15:0], {GSW_FRAC_W{1'b0}}};
				end else if (ce) begin
					if (param_reg[GSW_IDX_SMOOTH][15:0] == 16'h0) begin
						value_reg[ch] <= goal;
					end else if (tick) begin
						if (step > -$signed((VAL_W+1)'(1 << GSW_FRAC_W))
								&& step < $signed((VAL_W+1)'(1 << GSW_FRAC_W))) begin
							value_reg[ch] <= goal;
						end else begin
							value_reg[ch] <= VAL_W'($signed({1'b0, value_reg[ch]}) + step);
						end
					end
				end
			end
		end
	endgenerate

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign switch_active = active_reg;
	assign inertia_ratio_out = value_reg[0][VAL_W-1:GSW_FRAC_W];
	assign pos_loop_gain_out = value_reg[1][VAL_W-1:GSW_FRAC_W];
	assign spd_loop_gain_out = value_reg[2][VAL_W-1:GSW_FRAC_W];
	assign spd_integral_out = value_reg[3][VAL_W-1:GSW_FRAC_W];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_cond_zero;
		ce && param_reg[GSW_IDX_COND][3:0] == GSW_COND_OFF |=> !active_reg;
	endproperty
	a_cond_zero: assert property (p_cond_zero) else $error("switch on with condition zero");

	property p_not_manual;
		ce && !manual |=> !active_reg;
	endproperty
	a_not_manual: assert property (p_not_manual) else $error("switch on outside manual tuning");

	property p_di_on;
		ce && manual && param_reg[GSW_IDX_COND][3:0] == GSW_COND_DI_ON
			|=> active_reg == $past(gain_switch_in);
	endproperty
	a_di_on: assert property (p_di_on) else $error("input-on trigger wrong");

	property p_di_off;
		ce && manual && param_reg[GSW_IDX_COND][3:0] == GSW_COND_DI_OFF
			|=> active_reg == !$past(gain_switch_in);
	endproperty
	a_di_off: assert property (p_di_off) else $error("input-off trigger wrong");

	property p_freq_ge;
		ce && manual && param_reg[GSW_IDX_COND][3:0] == GSW_COND_FREQ_GE
			|=> active_reg == ($past(cmd_freq_kpps) >= $past(param_reg[GSW_IDX_THRESH]));
	endproperty
	a_freq_ge: assert property (p_freq_ge) else $error("frequency trigger wrong");

	property p_dev_le;
		ce && manual && param_reg[GSW_IDX_COND][3:0] == GSW_COND_DEV_LE
			|=> active_reg == ($past(pos_deviation) <= $past(param_reg[GSW_IDX_THRESH]));
	endproperty
	a_dev_le: assert property (p_dev_le) else $error("deviation trigger wrong");

	property p_spd_le;
		ce && manual && param_reg[GSW_IDX_COND][3:0] == GSW_COND_SPD_LE
			|=> active_reg == ($past(motor_speed_rpm) <= $past(param_reg[GSW_IDX_THRESH]));
	endproperty
	a_spd_le: assert property (p_spd_le) else $error("speed trigger wrong");

	property p_alt_inertia;
		ce && active_reg && !wr_fire && param_reg[GSW_IDX_SMOOTH] == 32'h0
			|=> inertia_ratio_out == param_reg[GSW_IDX_INERTIA_ALT][15:0];
	endproperty
	a_alt_inertia: assert property (p_alt_inertia) else $error("alternate inertia missing");

	property p_base_back;
		ce && !active_reg && !wr_fire && param_reg[GSW_IDX_SMOOTH] == 32'h0
			|=> pos_loop_gain_out == param_reg[GSW_IDX_POS_BASE][15:0];
	endproperty
	a_base_back: assert property (p_base_back) else $error("base gain not restored");

	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

	c_switch_on: cover property (ce && !active_reg ##1 active_reg);
	c_switch_off: cover property (ce && active_reg ##1 !active_reg);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read_status: cover property (s_axi_rvalid && s_axi_rdata[0]);

endmodule
`default_nettype wire

// File: test/gsw_motion_model.sv
// Behavioural far side: switch input terminal and motion feedback levels.
`timescale 1ns/1ps
`default_nettype none
module gsw_motion_model (
	input wire logic aclk,
	output logic gain_switch_in,
	output logic [31:0] cmd_freq_kpps,
	output logic [31:0] pos_deviation,
	output logic [31:0] motor_speed_rpm
);
	initial begin
		gain_switch_in = 1'b0;
		cmd_freq_kpps = 32'h0;
		pos_deviation = 32'h0;
		motor_speed_rpm = 32'h0;
	end
	// The switch function is taken as assigned to this terminal, so its level drives the input.
	task automatic apply(input logic i, input logic [31:0] f, input logic [31:0] d,
		input logic [31:0] s);
		@(posedge aclk);
		gain_switch_in <= i;
		cmd_freq_kpps <= f;
		pos_deviation <= d;
		motor_speed_rpm <= s;
	endtask
endmodule
`default_nettype wire

// File: test/gsw_gain_switch_tb.sv
// Self-checking bench for the gain switching selector.
`timescale 1ns/1ps
`default_nettype none
module gsw_gain_switch_tb
	import gsw_pkg::*;
;
	localparam int TICK = 10;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, vi, en;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rd, thr, vf, vd, vs;
	logic [3:0] wstrb;
	logic [1:0] rsp;
	logic [31:0] pv [11];
	logic [7:0] ca [5] = '{8'h10, 8'h14, 8'h20, 8'h04, 8'h18};
	logic [31:0] cv [5] = '{32'h9, 32'hffffffff, 32'h5, 32'h7d0, 32'h7d0};
	logic [31:0] ce_v [5] = '{32'h8, 32'h3d0900, 32'ha, 32'h400, 32'h3e8};
	wire logic awready, wready, bvalid, arready, rvalid, di, sw_act;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata, f, d, s;
	wire logic [15:0] o_in, o_pg, o_vg, o_vi;
	int error_cnt, checked;

	gsw_gain_switch #(.TICK_CYCLES(TICK), .ADDR_W(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.ce(en), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .gain_switch_in(di), .cmd_freq_kpps(f), .pos_deviation(d),
		.motor_speed_rpm(s), .switch_active(sw_act), .inertia_ratio_out(o_in),
		.pos_loop_gain_out(o_pg), .spd_loop_gain_out(o_vg), .spd_integral_out(o_vi));
	gsw_motion_model mdl_u (.aclk(aclk), .gain_switch_in(di), .cmd_freq_kpps(f),
		.pos_deviation(d), .motor_speed_rpm(s));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Ready and valid are registers, so the falling edge shows what the next rising edge takes.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic ah, rh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = arvalid && arready;
			rh = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
		rready <= 1'b0;
	endtask

	function automatic logic exp_act(input logic [3:0] c);
		case (c)
			4'h1: return vi;
			4'h2: return vf >= thr;
			4'h3: return vd >= thr;
			4'h4: return vs >= thr;
			4'h5: return !vi;
			4'h6: return vf <= thr;
			4'h7: return vd <= thr;
			4'h8: return vs <= thr;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] scale(input logic [31:0] b, input logic [31:0] p);
		return (b * p) / 100;
	endfunction

	function automatic logic [31:0] pick();
		case ($urandom_range(3))
			0: return thr - 1;
			1: return thr;
			2: return thr + 1;
			default: return $urandom_range(6000);
		endcase
	endfunction

	task automatic chk_outs(input logic a);
		chk("active", {31'h0, sw_act}, {31'h0, a});
		chk("inertia", {16'h0, o_in}, a ? pv[7] : pv[0]);
		chk("pos gain", {16'h0, o_pg}, a ? scale(pv[1], pv[8]) : pv[1]);
		chk("spd gain", {16'h0, o_vg}, a ? scale(pv[2], pv[9]) : pv[2]);
		chk("integral", {16'h0, o_vi}, a ? scale(pv[3], pv[10]) : pv[3]);
	endtask

	task automatic settle(input logic i);
		mdl_u.apply(i, vf, vd, vs);
		repeat (5) @(posedge aclk);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		end_sim();
	end

	initial begin
		rd = $urandom(32'h107b);
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		en = 1'b1;
		{awaddr, araddr, wdata, wstrb} = '0;
		wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 11; i++) pv[i] = GSW_RESET[i];
		chk_outs(1'b0);
		for (int i = 0; i < 12; i++) begin
			axi_rd(8'(4 * i));
			chk("reset value", rd, GSW_RESET[i]);
		end
		axi_rd(GSW_OFS_STATUS);
		chk("status", rd, 32'h2);
		axi_rd(8'h34);
		chk("unmapped resp", {30'h0, rsp}, {30'h0, GSW_RESP_SLVERR});
		chk("unmapped data", rd, 32'h0);
		axi_wr(GSW_OFS_STATUS, 32'h1);
		chk("status write", {30'h0, rsp}, {30'h0, GSW_RESP_SLVERR});
		for (int k = 0; k < 5; k++) begin
			axi_wr(ca[k], cv[k]);
			axi_rd(ca[k]);
			chk("clamped", rd, ce_v[k]);
		end
		$display("test registers done");
		for (int i = 0; i < 11; i++) begin
			if (i inside {[0:3], [7:10]}) begin
				pv[i] = GSW_MIN[i] + $urandom_range(GSW_MAX[i] - GSW_MIN[i]);
			end
			pv[6] = 32'h0;
			if (i != 4 && i != 5) axi_wr(8'(4 * i), pv[i]);
		end
		for (int c = 0; c < 9; c++) begin
			axi_wr(8'h10, c);
			for (int k = 0; k < 6; k++) begin
				thr = $urandom_range(2, 5000);
				axi_wr(8'h14, thr);
				vf = pick();
				vd = pick();
				vs = pick();
				vi = 1'($urandom_range(1));
				settle(vi);
				chk_outs(exp_act(4'(c)));
			end
		end
		$display("test conditions done");
		axi_wr(8'h10, 32'h1);
		axi_wr(8'h2c, 32'h2);
		settle(1'b1);
		chk_outs(1'b0);
		axi_wr(8'h2c, 32'h1);
		pv[8] = 32'h1f4;
		axi_wr(8'h20, pv[8]);
		settle(1'b1);
		chk_outs(1'b1);
		axi_rd(GSW_OFS_STATUS);
		chk("status", rd, 32'h3);
		$display("test tuning done");
		axi_wr(8'h18, 32'h4);
		settle(1'b0);
		repeat (TICK) @(posedge aclk);
		chk("smoothing", {31'h0, o_pg < scale(pv[1], pv[8]) && o_pg > pv[1]}, 32'h1);
		// The gain is still moving here, so a frozen output proves the enable gates the filter.
		en <= 1'b0;
		@(negedge aclk);
		rd = {16'h0, o_pg};
		repeat (3 * TICK) @(posedge aclk);
		chk("frozen gain", {16'h0, o_pg}, rd);
		en <= 1'b1;
		repeat (100 * TICK) @(posedge aclk);
		chk_outs(1'b0);
		$display("test smoothing done");
		end_sim();
	end
endmodule
`default_nettype wire
